// File: dv/fcd_dma_sva.sv
/*
 Port assertions of fcd_dma, bound into every instance.
 Assumes one clock domain with a synchronous active-low reset.
*/
`timescale 1ns/1ps
module fcd_dma_chk (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic arm_wr_i,
   input wire logic [7:0] arm_wdata_i,
   input wire logic [4:0] arm_o,
   input wire logic req_wr_i,
   input wire logic [4:0] req_wdata_i,
   input wire logic [4:0] req_o,
   input wire logic [4:0] flag_clr_i,
   input wire logic [4:0] flag_o,
   input wire logic irq_o,
   input wire logic [15:0] chan0_desc_ptr_i,
   input wire logic cpu_gnt_o,
   input wire logic mem_req_o,
   input wire logic mem_we_o,
   input wire logic [15:0] mem_addr_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   arm_set_a: assert property (arm_wr_i && !arm_wdata_i[7] |=>
      (arm_o & $past(arm_wdata_i[4:0])) == $past(arm_wdata_i[4:0])) else $error("arm bits not set");
   abort_clr_a: assert property (arm_wr_i && arm_wdata_i[7] |=>
      (arm_o & $past(arm_wdata_i[4:0])) == 5'h00) else $error("aborted channel still armed");
   // A write in the abort cycle may be the last of a unit; the abort suppresses its flag
   abort_flag_a: assert property (arm_wr_i && arm_wdata_i[7] && !mem_we_o |=>
      (flag_o & ~$past(flag_o) & $past(arm_wdata_i[4:0])) == 5'h00) else $error("abort set a flag");
   flag_hold_a: assert property ($past(rst_n_i) |->
      ($past(flag_o) & ~flag_o & ~$past(flag_clr_i)) == 5'h00) else $error("flag lost without clear");
   irq_cause_a: assert property (irq_o |-> flag_o != 5'h00) else $error("irq without flag");
   req_set_a: assert property (req_wr_i |=>
      (req_o & $past(req_wdata_i)) == $past(req_wdata_i)) else $error("request bit not set");
   req_clr_a: assert property ($past(rst_n_i) && ($past(req_o) & ~req_o) != 5'h00 |->
      mem_req_o && !mem_we_o) else $error("request cleared without transfer");
   fetch_len_a: assert property (arm_wr_i && arm_wdata_i == 8'h01 && arm_o == 5'h00 |->
      ##2 (mem_addr_o == chan0_desc_ptr_i) ##0 (mem_req_o && !mem_we_o)[*8] ##1 !mem_req_o)
      else $error("descriptor fetch wrong");
   word_pair_a: assert property (mem_req_o && mem_we_o ##1 mem_req_o && mem_we_o |->
      mem_addr_o == $past(mem_addr_o) + 16'h0001) else $error("word bytes not adjacent");
   cpu_excl_a: assert property (!(mem_req_o && cpu_gnt_o)) else $error("memory granted twice");
   cover property (flag_o[0] && irq_o);
   cover property (arm_wr_i && arm_wdata_i[7]);
   cover property (mem_req_o && mem_we_o ##1 mem_req_o && mem_we_o);
endmodule

bind fcd_dma fcd_dma_chk u_chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .arm_wr_i(arm_wr_i),
   .arm_wdata_i(arm_wdata_i), .arm_o(arm_o), .req_wr_i(req_wr_i), .req_wdata_i(req_wdata_i),
   .req_o(req_o), .flag_clr_i(flag_clr_i), .flag_o(flag_o), .irq_o(irq_o),
   .chan0_desc_ptr_i(chan0_desc_ptr_i), .cpu_gnt_o(cpu_gnt_o), .mem_req_o(mem_req_o),
   .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o));

// File: dv/fcd_dma_tb.sv
/*
 Self-checking bench of fcd_dma against a byte memory partner.
 Assumes the checker binds itself; port 1 pins and shared pointer are tied.
*/
`timescale 1ns/1ps
module fcd_dma_tb;
   logic clk_sys_i, rst_n_i, arm_wr_i, req_wr_i, irq_o, cpu_req_i, cpu_gnt_o, mem_req_o, mem_we_o;
   logic [7:0] arm_wdata_i, mem_wdata_o, mem_rdata_i, p0_pin;
   logic [4:0] arm_o, req_wdata_i, req_o, flag_clr_i, flag_o;
   logic [31:0] periph_trigger_select_field_i;
   logic [15:0] ptr0, mem_addr_o;
   int miscompares, n_tests;

   fcd_dma DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .arm_wr_i(arm_wr_i), .arm_wdata_i(arm_wdata_i),
      .arm_o(arm_o), .req_wr_i(req_wr_i), .req_wdata_i(req_wdata_i), .req_o(req_o), .flag_clr_i(flag_clr_i),
      .flag_o(flag_o), .irq_o(irq_o), .chan0_desc_ptr_i(ptr0), .chan1to4_desc_ptr_i(16'h0180),
      .periph_trigger_select_field_i(periph_trigger_select_field_i), .port0_pin_i(p0_pin), .port0_irq_en_i(8'h02), .port1_pin_i(8'h00),
      .port1_irq_en_i(8'h00), .cpu_req_i(cpu_req_i), .cpu_gnt_o(cpu_gnt_o), .mem_req_o(mem_req_o),
      .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i));
   fcd_mem_model m (.clk_sys_i(clk_sys_i), .mem_req_i(mem_req_o), .mem_we_i(mem_we_o),
      .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));

   initial begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask

   task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Descriptor bytes go out most significant first
   task automatic desc(input logic [15:0] a, input logic [47:0] sdn, input logic [15:0] cfg);
      logic [63:0] v;
      v = {sdn, cfg};
      for (int i = 0; i < 8; i++) m.mem_q[a + 16'(i)] = v[63 - 8 * i -: 8];
   endtask

   task automatic arm(input logic [7:0] d);
      arm_wr_i <= 1'b1;
      arm_wdata_i <= d;
      @(posedge clk_sys_i);
      arm_wr_i <= 1'b0;
   endtask

   task automatic swreq(input logic [4:0] b);
      req_wr_i <= 1'b1;
      req_wdata_i <= b;
      @(posedge clk_sys_i);
      req_wr_i <= 1'b0;
   endtask

   task automatic trigger_select_field(input int b);
      periph_trigger_select_field_i <= 32'h0000_0001 << b;
      @(posedge clk_sys_i);
      periph_trigger_select_field_i <= 32'h0000_0000;
   endtask

   task automatic wait_flag(input int ch);
      int k;
      k = 0;
      while (flag_o[ch] !== 1'b1 && k < 2000) begin
         @(posedge clk_sys_i);
         k++;
      end
      chk("flag", 8'(flag_o[ch]), 8'h01);
      cyc(2);
   endtask

   task automatic t_single;
      desc(ptr0, 48'h0200_0300_0002, 16'h0C5A);
      m.mem_q[16'h0200] = 8'hA1;
      m.mem_q[16'h0201] = 8'hB2;
      m.mem_q[16'h0301] = 8'h00;
      arm(8'h01);
      cyc(12);
      swreq(5'h01);
      cyc(8);
      chk("dst0", m.mem_q[16'h0300], 8'hA1);
      chk("arm0", 8'(arm_o[0]), 8'h01);
      chk("flag0", 8'(flag_o[0]), 8'h00);
      chk("req0", 8'(req_o[0]), 8'h00);
      // Only pin 1 of port 0 is enabled as a trigger source
      p0_pin <= 8'h01;
      cyc(8);
      chk("pin off", m.mem_q[16'h0301], 8'h00);
      p0_pin <= 8'h03;
      wait_flag(0);
      chk("dst1", m.mem_q[16'h0301], 8'hB2);
      chk("arm0 end", 8'(arm_o[0]), 8'h00);
      chk("irq", 8'(irq_o), 8'h01);
      flag_clr_i <= 5'h01;
      @(posedge clk_sys_i);
      flag_clr_i <= 5'h00;
      cyc(3);
      chk("irq clr", 8'(irq_o), 8'h00);
      $display("test single done");
   endtask

   task automatic t_block_word;
      // Length word 1 plus one gives two words of the four allowed
      desc(16'h0180, 48'h0400_0506_2004, 16'hA0B1);
      m.mem_q[16'h0400] = 8'h01;
      m.mem_q[16'h0401] = 8'h00;
      m.mem_q[16'h0502] = 8'h00;
      m.mem_q[16'h0404] = 8'h33;
      m.mem_q[16'h0405] = 8'h44;
      // The processor contends throughout; a normal channel still gets through
      cpu_req_i <= 1'b1;
      arm(8'h02);
      cyc(12);
      swreq(5'h02);
      wait_flag(1);
      cpu_req_i <= 1'b0;
      chk("w0 lo", m.mem_q[16'h0506], 8'h01);
      chk("w0 hi", m.mem_q[16'h0507], 8'h00);
      chk("vlen", m.mem_q[16'h0502], 8'h00);
      chk("w1 lo", m.mem_q[16'h0504], 8'h33);
      chk("w1 hi", m.mem_q[16'h0505], 8'h44);
      chk("arm1", 8'(arm_o[1]), 8'h00);
      chk("irq masked", 8'(irq_o), 8'h00);
      $display("test block word done");
   endtask

   task automatic t_trigger_select_field;
      desc(16'h0190, 48'h0600_0700_0001, 16'h4E50);
      m.mem_q[16'h0600] = 8'h5C;
      m.mem_q[16'h0700] = 8'h00;
      arm(8'h08);
      cyc(12);
      trigger_select_field(15);
      cyc(8);
      chk("other trigger_select_field", m.mem_q[16'h0700], 8'h00);
      trigger_select_field(14);
      wait_flag(3);
      chk("dst trigger_select_field", m.mem_q[16'h0700], 8'h5C);
      chk("rearmed", 8'(arm_o[3]), 8'h01);
      m.mem_q[16'h0600] = 8'h6D;
      trigger_select_field(14);
      cyc(10);
      chk("reload", m.mem_q[16'h0700], 8'h6D);
      $display("test trigger done");
   endtask

   task automatic t_abort;
      desc(16'h0188, 48'h0800_0900_0100, 16'h2056);
      arm(8'h04);
      cyc(12);
      swreq(5'h04);
      cyc(20);
      arm(8'h84);
      cyc(4);
      chk("arm2", 8'(arm_o[2]), 8'h00);
      chk("arm3 kept", 8'(arm_o[3]), 8'h01);
      chk("flag2", 8'(flag_o[2]), 8'h00);
      chk("irq", 8'(irq_o), 8'h00);
      chk("mem idle", 8'(mem_req_o), 8'h00);
      $display("test abort done");
   endtask

   initial begin
      {rst_n_i, arm_wr_i, req_wr_i, cpu_req_i} = 4'h0;
      {arm_wdata_i, req_wdata_i, flag_clr_i} = 18'h0_0000;
      periph_trigger_select_field_i = 32'h0000_0000;
      ptr0 = 16'h0100;
      p0_pin = 8'h00;
      cyc(10);
      rst_n_i <= 1'b1;
      @(posedge clk_sys_i);
      t_single();
      t_block_word();
      t_trigger_select_field();
      t_abort();
      results();
   end

   initial begin
      cyc(5000);
      miscompares++;
      $display("watchdog expired");
      results();
   end
endmodule

// File: dv/fcd_mem_model.sv
/*
 Byte memory on the far side of fcd_dma, one-cycle read latency.
 Assumes the bench preloads and inspects mem_q by hierarchy.
*/
`timescale 1ns/1ps
module fcd_mem_model (
   input wire logic clk_sys_i,
   input wire logic mem_req_i,
   input wire logic mem_we_i,
   input wire logic [15:0] mem_addr_i,
   input wire logic [7:0] mem_wdata_i,
   output logic [7:0] mem_rdata_o
);
   logic [7:0] mem_q [0:65535];
   logic [7:0] last_q;
   logic vld_q;
   always @(posedge clk_sys_i) begin
      vld_q <= mem_req_i && !mem_we_i;
      if (mem_req_i && mem_we_i) begin
         mem_q[mem_addr_i] <= mem_wdata_i;
      end
      if (mem_req_i && !mem_we_i) begin
         last_q <= mem_q[mem_addr_i];
      end
   end
   // Off the answer cycle the bus shows the inverse, so a late capture is caught
   assign mem_rdata_o = vld_q ? last_q : ~last_q;
endmodule

// File: hdl/fcd_dma.sv
/*
 Five-channel DMA engine: descriptor fetch, trigger selection, channel and
 processor arbitration, byte/word moves over a single-port byte memory.
 Assumes memory accepts an access in any cycle mem_req_o is high and returns
 read data in the following cycle; triggers are one-cycle pulses on clk_sys_i.
*/
// How it works
// - Each channel reacts to the trigger its five-bit field selects and to its software request bit.
// - Arming or rearming copies descriptor start addresses into working pointers.
// - Pointers step by 0, +1, +2 or -1 counts; a word count is two bytes.
// - Single: one transfer per trigger; at count, flag and disarm.
// - Repeated single: one transfer per trigger; at count, flag and rearm.
// - Block: one trigger moves the whole count, then flag and disarm.
// - Repeated block: one trigger moves the whole count, then flag and rearm.
// - Highest priority channel wins; equal priorities rotate round robin.
// - High priority channel always beats a coinciding processor access.
// - Normal priority channel beats the processor at least every second try.
// - Low priority channel always yields to the processor.
// - Word-size bit selects byte or 16-bit word per transfer.
// - Byte transfers take 7 or 8 length bits; ignored for words.
// - Arming fetches the eight-byte descriptor from the pointer address.
// - Channel 0 own pointer; channels 1-4 in one contiguous 32-byte area.
// - Abort bit with arm bits disarms exactly the chosen channels.
// - Abort sets no completion flag and raises no interrupt.
// - Completion always sets its flag; mask only gates the interrupt.
// - Descriptor fields are big-endian; moved words are little-endian.
// - Trigger 0 is software only; trigger 1 is previous channel completion.
// - Triggers up to 31 map peripheral events to channels.
// - Port triggers 12 and 13 fire on any enabled pin transition.
// - Descriptor fetch takes nine clocks; earlier triggers are lost.
// - Software request clears only when its transfer takes place.
// - Mode codes: 00 single, 01 block, 10 repeated single, 11 repeated block.
// - Step codes: 00 none, 01 plus one, 10 plus two, 11 minus one.
`timescale 1ns/1ps
`include "fcd_dma_regs.svh"

module fcd_dma (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic arm_wr_i,
   input wire logic [7:0] arm_wdata_i,
   output logic [4:0] arm_o,
   input wire logic req_wr_i,
   input wire logic [4:0] req_wdata_i,
   output logic [4:0] req_o,
   input wire logic [4:0] flag_clr_i,
   output logic [4:0] flag_o,
   output logic irq_o,
   input wire logic [15:0] chan0_desc_ptr_i,
   input wire logic [15:0] chan1to4_desc_ptr_i,
   input wire logic [31:0] periph_trigger_select_field_i,
   input wire logic [7:0] port0_pin_i,
   input wire logic [7:0] port0_irq_en_i,
   input wire logic [7:0] port1_pin_i,
   input wire logic [7:0] port1_irq_en_i,
   input wire logic cpu_req_i,
   output logic cpu_gnt_o,
   output logic mem_req_o,
   output logic mem_we_o,
   output logic [15:0] mem_addr_o,
   output logic [7:0] mem_wdata_o,
   input wire logic [7:0] mem_rdata_i
);

   fcd_dma_pkg::fcd_state_type state_q;
   logic [2:0] cur_q, rr_q;
   logic idx_q, owed_q, irq_q;
   logic [3:0] fcnt_q;
   logic [7:0] buf_q [0:1];
   logic mem_req_q, mem_we_q;
   logic [15:0] mem_addr_q;
   logic [7:0] mem_wdata_q;
   logic [7:0] desc_q [0:4][0:7];
   logic [15:0] src_q [0:4];
   logic [15:0] dst_q [0:4];
   logic [12:0] cnt_q [0:4];
   logic [12:0] tgt_q [0:4];
   logic [4:0] arm_q, rdy_q, need_q, pend_q, req_q, flag_q, done_q;
   logic [4:0] arm_d, rdy_d, need_d, pend_d, req_d, flag_d;
   logic [7:0] p0_s1_q, p0_s2_q, p0_s3_q, p1_s1_q, p1_s2_q, p1_s3_q;

   logic [4:0] ch_trigger_select_field [0:4];
   logic [1:0] ch_mode [0:4];
   logic [1:0] ch_lvl [0:4];
   logic [12:0] ch_len [0:4];
   logic [4:0] ch_word, ch_irqen, hit, cand;

   function automatic logic [15:0] step_addr(input logic [15:0] a, input logic [1:0] inc, input logic word);
      logic [15:0] d;
      d = 16'h0000;
      case (inc)
         fcd_dma_pkg::FCD_STEP_NONE: d = 16'h0000;
         fcd_dma_pkg::FCD_STEP_PLUS1: d = 16'h0001;
         fcd_dma_pkg::FCD_STEP_PLUS2: d = 16'h0002;
         default: d = 16'hffff;
      endcase
      if (word) begin
         d = {d[14:0], 1'b0};
      end
      return a + d;
   endfunction

   function automatic logic [4:0] onehot(input logic [2:0] c);
      return 5'(5'h01 << c);
   endfunction

   // Pin transitions come from another domain, hence two flops before the edge compare
   wire port0_tr = |((p0_s2_q ^ p0_s3_q) & port0_irq_en_i);
   wire port1_tr = |((p1_s2_q ^ p1_s3_q) & port1_irq_en_i);
   wire [31:0] base_trigger_select_field = {periph_trigger_select_field_i[31:`FCD_TRIGGER_SELECT_FIELD_PORT1 + 1], port1_tr, port0_tr,
                            periph_trigger_select_field_i[`FCD_TRIGGER_SELECT_FIELD_PORT0 - 1:2], 2'b00};

   genvar g;
   for (g = 0; g < `FCD_NUM_CH; g++) begin : g_ch
      localparam int PREV = (g == 0) ? `FCD_NUM_CH - 1 : g - 1;
      wire [1:0] prio = desc_q[g][`FCD_B_STEP][`FCD_PRIO_MSB:`FCD_PRIO_LSB];
      assign ch_trigger_select_field[g] = desc_q[g][`FCD_B_CTRL][`FCD_TRIGGER_SELECT_FIELD_MSB:0];
      assign ch_mode[g] = desc_q[g][`FCD_B_CTRL][`FCD_MODE_MSB:`FCD_MODE_LSB];
      assign ch_word[g] = desc_q[g][`FCD_B_CTRL][`FCD_WORD_BIT];
      assign ch_irqen[g] = desc_q[g][`FCD_B_STEP][`FCD_IRQM_BIT];
      assign ch_len[g] = {desc_q[g][`FCD_B_LEN_HI][`FCD_LENH_MSB:0], desc_q[g][`FCD_B_LEN_LO]};
      assign ch_lvl[g] = prio[1] ? fcd_dma_pkg::FCD_PRIO_HIGH : prio;
      // Only the selected source is looked at; all others are ignored
      assign hit[g] = (ch_trigger_select_field[g] == `FCD_TRIGGER_SELECT_FIELD_PREV) ? done_q[PREV] : base_trigger_select_field[ch_trigger_select_field[g]];
      assign cand[g] = arm_q[g] & rdy_q[g] & (pend_q[g] | req_q[g]);
   end

   // Channel arbitration: strict level, ties go to the first after the last served
   logic [2:0] best_ch;
   logic [1:0] best_lvl;
   logic found;
   always_comb begin
      int idx;
      idx = 0;
      best_ch = 3'h0;
      best_lvl = 2'h0;
      found = 1'b0;
      for (int k = 1; k <= `FCD_NUM_CH; k++) begin
         idx = int'(rr_q) + k;
         if (idx >= `FCD_NUM_CH) begin
            idx = idx - `FCD_NUM_CH;
         end
         if (cand[idx] && (!found || ch_lvl[idx] > best_lvl)) begin
            best_ch = 3'(idx);
            best_lvl = ch_lvl[idx];
            found = 1'b1;
         end
      end
   end

   wire [4:0] abort_sel = (arm_wr_i & arm_wdata_i[`FCD_ARM_ABORT_BIT]) ? arm_wdata_i[4:0] : `FCD_CH_RST;
   wire [4:0] arm_set = (arm_wr_i & ~arm_wdata_i[`FCD_ARM_ABORT_BIT]) ? arm_wdata_i[4:0] : `FCD_CH_RST;
   wire in_idle = (state_q == fcd_dma_pkg::FCD_ST_IDLE);
   wire fetch_go = in_idle & (|need_q);
   wire contest = in_idle & ~(|need_q) & found & cpu_req_i;
   wire dma_win = found & (~cpu_req_i | (best_lvl == fcd_dma_pkg::FCD_PRIO_HIGH) |
                           ((best_lvl == fcd_dma_pkg::FCD_PRIO_NORMAL) & owed_q));
   // A unit starting in the abort cycle would outlive the abort pulse
   wire go = in_idle & ~(|need_q) & dma_win & ~abort_sel[best_ch];
   assign cpu_gnt_o = cpu_req_i & ~mem_req_q & ~fetch_go & ~go;

   // Fetch order is channel 1 to 4, then channel 0
   wire [2:0] fch = need_q[1] ? 3'h1 : need_q[2] ? 3'h2 : need_q[3] ? 3'h3 : need_q[4] ? 3'h4 : 3'h0;
   wire [2:0] fch_m1 = fch - 3'h1;
   wire [15:0] fbase = (fch == 3'h0) ? chan0_desc_ptr_i :
                       chan1to4_desc_ptr_i + {11'h000, fch_m1[1:0], 3'h0};

   wire cur_abort = abort_sel[cur_q] & ~in_idle;

   // Current channel fields
   wire cw = ch_word[cur_q];
   wire [1:0] cmode = ch_mode[cur_q];
   wire cm8 = desc_q[cur_q][`FCD_B_STEP][`FCD_M8_BIT];
   wire [2:0] cvlen = desc_q[cur_q][`FCD_B_LEN_HI][`FCD_VLEN_MSB:`FCD_VLEN_LSB];
   wire [1:0] csinc = desc_q[cur_q][`FCD_B_STEP][`FCD_SOURCE_STEP_FIELD_MSB:`FCD_SOURCE_STEP_FIELD_LSB];
   wire [1:0] cdinc = desc_q[cur_q][`FCD_B_STEP][`FCD_DSTINC_MSB:`FCD_DSTINC_LSB];
   wire [15:0] desc_src = {desc_q[cur_q][`FCD_B_SRC_HI], desc_q[cur_q][`FCD_B_SRC_LO]};
   wire [15:0] desc_dst = {desc_q[cur_q][`FCD_B_DST_HI], desc_q[cur_q][`FCD_B_DST_LO]};
   wire [12:0] clen = ch_len[cur_q];

   // Variable length from the first unit moved; words are low byte first
   wire [12:0] len_raw = cw ? {buf_q[1][4:0], buf_q[0]} :
                         cm8 ? {6'h00, buf_q[0][6:0]} : {5'h00, buf_q[0]};
   wire [13:0] vadd = (cvlen == fcd_dma_pkg::FCD_VLEN_P1) ? 14'h0001 :
                      (cvlen == fcd_dma_pkg::FCD_VLEN_P2) ? 14'h0002 :
                      (cvlen == fcd_dma_pkg::FCD_VLEN_P3) ? 14'h0003 : 14'h0000;
   wire [13:0] vsum = {1'b0, len_raw} + vadd;
   wire [12:0] vtgt = (vsum > {1'b0, clen}) ? clen : vsum[12:0];
   wire is_var = (cvlen >= fcd_dma_pkg::FCD_VLEN_P1) & (cvlen <= fcd_dma_pkg::FCD_VLEN_P3);
   wire first = (cnt_q[cur_q] == `FCD_CNT_RST);
   wire [12:0] eff_tgt = (is_var & first) ? vtgt : tgt_q[cur_q];
   wire [12:0] new_cnt = cnt_q[cur_q] + 13'h0001;
   wire reached = (new_cnt >= eff_tgt);
   wire rep = (cmode == fcd_dma_pkg::FCD_MODE_RSINGLE) | (cmode == fcd_dma_pkg::FCD_MODE_RBLOCK);
   wire blk = (cmode == fcd_dma_pkg::FCD_MODE_BLOCK) | (cmode == fcd_dma_pkg::FCD_MODE_RBLOCK);

   wire unit_end = (state_q == fcd_dma_pkg::FCD_ST_WR) & (idx_q | ~cw) & ~cur_abort;
   wire unit_fin = unit_end & reached;
   wire fetch_fin = (state_q == fcd_dma_pkg::FCD_ST_FETCH) & (fcnt_q == `FCD_FETCH_LAST_CYCLE) & ~cur_abort;
   wire [4:0] fin_mask = fetch_fin ? onehot(cur_q) : `FCD_CH_RST;
   wire [4:0] done_mask = unit_fin ? onehot(cur_q) : `FCD_CH_RST;
   wire [4:0] dis_mask = (unit_fin & ~rep) ? onehot(cur_q) : `FCD_CH_RST;
   wire [4:0] go_mask = go ? onehot(best_ch) : `FCD_CH_RST;
   wire [4:0] single_go = (go & ~ch_mode[best_ch][0]) ? go_mask : `FCD_CH_RST;
   wire [4:0] block_end = (unit_fin & blk) ? onehot(cur_q) : `FCD_CH_RST;

   assign arm_d = ((arm_q & ~dis_mask) | arm_set) & ~abort_sel;
   assign need_d = ((need_q & ~fin_mask) | arm_set) & ~abort_sel;
   assign rdy_d = (rdy_q | fin_mask) & ~arm_set & ~abort_sel;
   // A trigger is only caught once the fetch is done; earlier ones are lost
   // A started block stays pending until its last unit, whatever started it
   assign pend_d = ((pend_q & ~single_go & ~block_end) | (hit & arm_q & rdy_q) |
                    (go_mask & ~single_go)) & arm_d & ~arm_set;
   assign req_d = (req_q & ~go_mask) | (req_wr_i ? req_wdata_i : `FCD_CH_RST);
   assign flag_d = (flag_q & ~flag_clr_i) | done_mask;

   assign arm_o = arm_q;
   assign req_o = req_q;
   assign flag_o = flag_q;
   assign irq_o = irq_q;
   assign mem_req_o = mem_req_q;
   assign mem_we_o = mem_we_q;
   assign mem_addr_o = mem_addr_q;
   assign mem_wdata_o = mem_wdata_q;

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         {p0_s3_q, p0_s2_q, p0_s1_q} <= 24'h00_0000;
         {p1_s3_q, p1_s2_q, p1_s1_q} <= 24'h00_0000;
      end else begin
         {p0_s3_q, p0_s2_q, p0_s1_q} <= {p0_s2_q, p0_s1_q, port0_pin_i};
         {p1_s3_q, p1_s2_q, p1_s1_q} <= {p1_s2_q, p1_s1_q, port1_pin_i};
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         arm_q <= `FCD_CH_RST;
         need_q <= `FCD_CH_RST;
         rdy_q <= `FCD_CH_RST;
         pend_q <= `FCD_CH_RST;
         req_q <= `FCD_CH_RST;
         flag_q <= `FCD_CH_RST;
         done_q <= `FCD_CH_RST;
         irq_q <= 1'b0;
         owed_q <= 1'b0;
         rr_q <= 3'h0;
      end else begin
         arm_q <= arm_d;
         need_q <= need_d;
         rdy_q <= rdy_d;
         pend_q <= pend_d;
         req_q <= req_d;
         flag_q <= flag_d;
         done_q <= done_mask;
         irq_q <= |(flag_d & ch_irqen);
         if (contest && best_lvl == fcd_dma_pkg::FCD_PRIO_NORMAL) begin
            owed_q <= ~owed_q;
         end
         if (go) begin
            rr_q <= best_ch;
         end
      end
   end

   // Engine; the channel arrays hold no reset as they are loaded by the fetch
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         state_q <= fcd_dma_pkg::FCD_ST_IDLE;
         cur_q <= 3'h0;
         idx_q <= 1'b0;
         fcnt_q <= 4'h0;
         mem_req_q <= 1'b0;
         mem_we_q <= 1'b0;
         mem_addr_q <= `FCD_ADDR_RST;
         mem_wdata_q <= 8'h00;
      end else if (cur_abort) begin
         state_q <= fcd_dma_pkg::FCD_ST_IDLE;
         mem_req_q <= 1'b0;
         mem_we_q <= 1'b0;
      end else begin
         case (state_q)
            fcd_dma_pkg::FCD_ST_IDLE: begin
               if (fetch_go) begin
                  cur_q <= fch;
                  fcnt_q <= 4'h0;
                  mem_req_q <= 1'b1;
                  mem_we_q <= 1'b0;
                  mem_addr_q <= fbase;
                  state_q <= fcd_dma_pkg::FCD_ST_FETCH;
               end else if (go) begin
                  cur_q <= best_ch;
                  idx_q <= 1'b0;
                  mem_req_q <= 1'b1;
                  mem_we_q <= 1'b0;
                  mem_addr_q <= src_q[best_ch];
                  state_q <= fcd_dma_pkg::FCD_ST_RD;
               end
            end
            fcd_dma_pkg::FCD_ST_FETCH: begin
               if (fcnt_q != 4'h0) begin
                  desc_q[cur_q][3'(fcnt_q - 4'h1)] <= mem_rdata_i;
               end
               if (fcnt_q[2:0] == `FCD_DESC_LAST_BYTE || fcnt_q[3]) begin
                  mem_req_q <= 1'b0;
               end else begin
                  mem_addr_q <= mem_addr_q + 16'h0001;
               end
               fcnt_q <= fcnt_q + 4'h1;
               // Nine clocks from the first read to a ready channel
               if (fcnt_q == `FCD_FETCH_LAST_CYCLE) begin
                  src_q[cur_q] <= desc_src;
                  dst_q[cur_q] <= desc_dst;
                  cnt_q[cur_q] <= `FCD_CNT_RST;
                  tgt_q[cur_q] <= clen;
                  state_q <= fcd_dma_pkg::FCD_ST_IDLE;
               end
            end
            fcd_dma_pkg::FCD_ST_RD: begin
               mem_req_q <= 1'b0;
               state_q <= fcd_dma_pkg::FCD_ST_LAT;
            end
            fcd_dma_pkg::FCD_ST_LAT: begin
               buf_q[idx_q] <= mem_rdata_i;
               mem_req_q <= 1'b1;
               if (cw && !idx_q) begin
                  idx_q <= 1'b1;
                  mem_addr_q <= src_q[cur_q] + 16'h0001;
                  state_q <= fcd_dma_pkg::FCD_ST_RD;
               end else begin
                  idx_q <= 1'b0;
                  mem_we_q <= 1'b1;
                  mem_addr_q <= dst_q[cur_q];
                  mem_wdata_q <= idx_q ? buf_q[0] : mem_rdata_i;
                  state_q <= fcd_dma_pkg::FCD_ST_WR;
               end
            end
            fcd_dma_pkg::FCD_ST_WR: begin
               if (cw && !idx_q) begin
                  idx_q <= 1'b1;
                  mem_addr_q <= dst_q[cur_q] + 16'h0001;
                  mem_wdata_q <= buf_q[1];
               end else begin
                  mem_req_q <= 1'b0;
                  mem_we_q <= 1'b0;
                  idx_q <= 1'b0;
                  state_q <= fcd_dma_pkg::FCD_ST_IDLE;
                  if (reached && rep) begin
                     src_q[cur_q] <= desc_src;
                     dst_q[cur_q] <= desc_dst;
                     cnt_q[cur_q] <= `FCD_CNT_RST;
                     tgt_q[cur_q] <= clen;
                  end else begin
                     src_q[cur_q] <= step_addr(src_q[cur_q], csinc, cw);
                     dst_q[cur_q] <= step_addr(dst_q[cur_q], cdinc, cw);
                     cnt_q[cur_q] <= reached ? `FCD_CNT_RST : new_cnt;
                     tgt_q[cur_q] <= eff_tgt;
                  end
               end
            end
            default: begin
               state_q <= fcd_dma_pkg::FCD_ST_IDLE;
               mem_req_q <= 1'b0;
               mem_we_q <= 1'b0;
            end
         endcase
      end
   end

endmodule

// File: hdl/fcd_dma_pkg.sv
/*
 Types of the five-channel DMA controller: engine states and the
 descriptor field encodings. Assumes nothing of its surroundings.
*/
package fcd_dma_pkg;

   typedef enum logic [2:0] {
      FCD_ST_IDLE  = 3'h0,
      FCD_ST_FETCH = 3'h1,
      FCD_ST_RD    = 3'h3,
      FCD_ST_LAT   = 3'h2,
      FCD_ST_WR    = 3'h6
   } fcd_state_type;

   typedef enum logic [1:0] {
      FCD_MODE_SINGLE  = 2'h0,
      FCD_MODE_BLOCK   = 2'h1,
      FCD_MODE_RSINGLE = 2'h2,
      FCD_MODE_RBLOCK  = 2'h3
   } fcd_mode_type;

   typedef enum logic [1:0] {
      FCD_STEP_NONE   = 2'h0,
      FCD_STEP_PLUS1  = 2'h1,
      FCD_STEP_PLUS2  = 2'h2,
      FCD_STEP_MINUS1 = 2'h3
   } fcd_step_type;

   typedef enum logic [2:0] {
      FCD_VLEN_FIXED = 3'h0,
      FCD_VLEN_P1    = 3'h1,
      FCD_VLEN_P0    = 3'h2,
      FCD_VLEN_P2    = 3'h3,
      FCD_VLEN_P3    = 3'h4,
      FCD_VLEN_RSV5  = 3'h5,
      FCD_VLEN_RSV6  = 3'h6,
      FCD_VLEN_ALT   = 3'h7
   } fcd_vlen_type;

   typedef enum logic [1:0] {
      FCD_PRIO_LOW    = 2'h0,
      FCD_PRIO_NORMAL = 2'h1,
      FCD_PRIO_HIGH   = 2'h2
   } fcd_prio_type;

endpackage

// File: hdl/fcd_dma_regs.svh
/*
 Offsets, field positions, reset values and timing counts of the
 five-channel DMA controller. Assumes inclusion by bare name from hdl/.
*/
`ifndef FCD_DMA_REGS_SVH
`define FCD_DMA_REGS_SVH

`define FCD_NUM_CH 5
`define FCD_ARM_ABORT_BIT 7
`define FCD_DESC_LAST_BYTE 3'h7
`define FCD_FETCH_LAST_CYCLE 4'h8
`define FCD_DESC_STRIDE_LSB 3
`define FCD_TRIGGER_SELECT_FIELD_PREV 5'h01
`define FCD_TRIGGER_SELECT_FIELD_PORT0 12
`define FCD_TRIGGER_SELECT_FIELD_PORT1 13

// Descriptor byte offsets, multi-byte fields big-endian
`define FCD_B_SRC_HI 0
`define FCD_B_SRC_LO 1
`define FCD_B_DST_HI 2
`define FCD_B_DST_LO 3
`define FCD_B_LEN_HI 4
`define FCD_B_LEN_LO 5
`define FCD_B_CTRL 6
`define FCD_B_STEP 7

// Field positions
`define FCD_VLEN_MSB 7
`define FCD_VLEN_LSB 5
`define FCD_LENH_MSB 4
`define FCD_WORD_BIT 7
`define FCD_MODE_MSB 6
`define FCD_MODE_LSB 5
`define FCD_TRIGGER_SELECT_FIELD_MSB 4
`define FCD_SOURCE_STEP_FIELD_MSB 7
`define FCD_SOURCE_STEP_FIELD_LSB 6
`define FCD_DSTINC_MSB 5
`define FCD_DSTINC_LSB 4
`define FCD_IRQM_BIT 3
`define FCD_M8_BIT 2
`define FCD_PRIO_MSB 1
`define FCD_PRIO_LSB 0

// Reset values
`define FCD_CH_RST 5'h00
`define FCD_ADDR_RST 16'h0000
`define FCD_CNT_RST 13'h0000

`endif
